//--- time_processor_pkg.sv
// Purpose: shared constants and types for the time processor core
// Assumes: 16 channels, 16-bit time bases, 128-word parameter memory
// Notes:   field layouts of the config and control words are fixed here
package time_processor_pkg;
   // =========================================================
   // sizes
   localparam int             NUM_CH         = 16;   // pin channels
   localparam int             PRAM_DEPTH     = 128;  // 16-bit parameter words
   localparam logic [15:0]    TB_MAX         = 16'hFFFF; // top of a time base
   // =========================================================
   // module config word fields
   localparam int             CFG_TB1_PS_LSB = 0;    // 2-bit divide select
   localparam int             CFG_TB2_PS_LSB = 2;    // 2-bit divide select
   localparam int             CFG_TB2_EXT    = 4;    // second base from pin
   // =========================================================
   // channel control word fields
   localparam int             CTL_PSC_LSB    = 0;    // pin state force field
   localparam int             CTL_PAC_LSB    = 2;    // pin action field
   localparam int             CTL_DIR        = 4;    // pin direction select: output
   localparam int             CTL_MTB2       = 5;    // timebase select: match
   localparam int             CTL_CTB2       = 6;    // timebase select: capture
   localparam int             CTL_ARM        = 7;    // arm match detection
   localparam logic [1:0]     PSC_HIGH       = 2'h1; // force pin high
   localparam logic [1:0]     PSC_LOW        = 2'h2; // force pin low
   // =========================================================
   // parameter word slots
   localparam logic [6:0]     PW_CTL         = 7'h0; // control word
   localparam logic [6:0]     PW_PERIOD      = 7'h1; // match increment
   localparam logic [6:0]     PW_CAPT        = 7'h2; // captured time
   localparam logic [6:0]     PW_TIME        = 7'h3; // time count load value
   localparam logic [6:0]     SLOT_SMALL     = 7'h6; // words per low channel
   localparam logic [6:0]     SLOT_LARGE     = 7'h8; // words per high channel
   localparam logic [3:0]     LARGE_FIRST    = 4'hE; // first eight-word channel
   localparam logic [6:0]     LARGE_BASE     = 7'h54; // word of channel 14
   // =========================================================
   // microcode opcode bits and factory table (4 bits per function)
   localparam int             OP_REARM       = 0;
   localparam int             OP_STORE_CAPT  = 1;
   localparam int             OP_LINK        = 2;
   localparam int             OP_LOAD_TIME   = 3;
   localparam logic [63:0]    UCODE_ROM      = 64'h0000_8421_3573_1203;
   // =========================================================
   typedef enum logic [1:0] {
      PRI_OFF  = 2'h0,
      PRI_LOW  = 2'h1,
      PRI_MID  = 2'h2,
      PRI_HIGH = 2'h3
   } pri_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_EXEC  = 3'b100
   } eng_state_t;
   typedef struct packed {
      logic [1:0] pin_action_field;       // edge select / match level
      logic       dir_out;   // pin driven
      logic       match_tb2; // match on second base
      logic       cap_tb2;   // capture from second base
      logic       armed;     // match detection live
   } chan_cfg_t;
   typedef struct packed {
      logic        req;      // access strobe
      logic        we;       // write
      logic        long_acc; // coherent pair at even word
      logic [6:0]  addr;     // word address
      logic [31:0] wdata;    // high word at addr, low word at addr+1
   } host_pram_req_t;
endpackage : time_processor_pkg

//--- time_processor_core.sv
// Purpose: timing coprocessor with two time bases and sixteen channels
// Assumes: host and engine share parameter memory, engine write has priority
// Notes:   microengine is a compact fixed-step executor of opcode bits
// Operation
// - two free-running 16-bit time bases
// - prescalers set by config word fields
// - only microengine writes counts, and only the first base
// - second base may count external clock pin
// - sixteen identical channels, one pin each
// - capture, compare, greater-or-equal comparator per channel
// - microengine sets pin direction
// - separate time base for match and capture
// - host, link, match, capture raise requests
// - same-level ties broken by channel number
// - serve others in order before repeating
// - new requests join the round unless their channel was served
// - events detected by per-channel hardware
// - events request service; scheduler assigns engine
// - microcode from ROM or emulation RAM
// - shared memory of 128 16-bit words
// - six words low channels, eight for 14-15
// - control word holds force, action, select
// - action field picks edge or match level
// - long-word accesses move word pairs coherently
// - channels link the next channel
`timescale 1ns/1ns
module time_processor_core (
   input  wire logic                                  i_clock,
   input  wire logic                                  i_rst_n,
   input  wire logic [15:0]                           i_module_config_word,
   input  wire logic                                  i_ext_timebase_clock_pin,
   input  wire logic [15:0]                           i_ch_pin,
   input  wire logic [15:0]                           i_host_req,
   input  wire logic [31:0]                           i_ch_priority,
   input  wire logic [63:0]                           i_ch_function,
   input  wire logic                                  i_emu_select,
   input  wire logic                                  i_emu_wr,
   input  wire logic [3:0]                            i_emu_addr,
   input  wire logic [3:0]                            i_emu_data,
   input  wire time_processor_pkg::host_pram_req_t    i_host_pram,
   output logic      [31:0]                           o_host_pram_rdata,
   output logic                                       o_host_pram_ack,
   output logic      [15:0]                           o_ch_pin_out,
   output logic      [15:0]                           o_ch_pin_oe,
   output logic                                       o_service_busy,
   output logic      [3:0]                            o_service_channel
);
   // =========================================================
   // declarations
   logic [15:0]  pram_q [time_processor_pkg::PRAM_DEPTH]; // shared words
   logic [3:0]   emu_ram_q [16];                 // emulation microcode
   logic [15:0]  tb1_q, tb2_q;                   // time counts
   logic [2:0]   ps1_q, ps2_q;                   // prescaler counters
   logic         tick1, tick2, src2;             // base increments
   logic [2:0]   ext_sync_q;                     // pin sync plus edge stage
   logic [15:0]  pin_s1_q, pin_s2_q, pin_prev_q; // channel pin sync
   logic [15:0]  req_q;                          // latched service requests
   logic [15:0]  match_evt, capt_evt, link_set;  // request causes
   logic [15:0]  done_q [4];                     // served-this-round masks
   logic [15:0]  lvl_req [4];                    // requests per level
   logic [1:0]   top_lvl;                        // highest busy level
   logic [15:0]  cand;                           // eligible requests
   logic         round_new;                      // round restarts
   logic [3:0]   grant;                          // chosen channel
   logic         start;                          // service begins
   time_processor_pkg::eng_state_t state_q;      // engine state
   logic [3:0]   cur_q;                          // channel in service
   logic [3:0]   op_q;                           // fetched opcode
   logic [15:0]  ctl_q, period_q, time_q;        // fetched parameters
   logic [6:0]   base;                           // parameter slot of cur_q
   logic         eng_wr, host_ok;                // memory port arbitration
   logic [15:0]  cmp_q [16];                     // compare registers
   logic [15:0]  cap_q [16];                     // capture registers
   time_processor_pkg::chan_cfg_t cfg_q [16];    // channel setup

   // lowest set bit index
   function automatic logic [3:0] lowest(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 15; k >= 0; k--) begin
         if (v[k]) begin
            r = 4'(k);
         end
      end
      return r;
   endfunction : lowest

   // =========================================================
   // time bases
   assign src2  = i_module_config_word[time_processor_pkg::CFG_TB2_EXT]
                  ? (ext_sync_q[1] & ~ext_sync_q[2]) : 1'b1;
   assign tick1 = (ps1_q == 3'((4'h1 << i_module_config_word[
                  time_processor_pkg::CFG_TB1_PS_LSB +: 2]) - 4'h1));
   assign tick2 = src2 & (ps2_q == 3'((4'h1 << i_module_config_word[
                  time_processor_pkg::CFG_TB2_PS_LSB +: 2]) - 4'h1));

   // external clock pin synchroniser and edge stage
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ext_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], i_ext_timebase_clock_pin};
      end
   end

   // prescaler counters
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ps1_q <= 3'h0;
         ps2_q <= 3'h0;
      end else begin
         ps1_q <= tick1 ? 3'h0 : ps1_q + 3'h1;
         if (src2) begin
            ps2_q <= tick2 ? 3'h0 : ps2_q + 3'h1;
         end
      end
   end

   // counters wrap naturally; engine may load the first one
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tb1_q <= 16'h0000;
         tb2_q <= 16'h0000;
      end else begin
         if (state_q == time_processor_pkg::ST_EXEC && op_q[time_processor_pkg::OP_LOAD_TIME]) begin
            tb1_q <= time_q;
         end else if (tick1) begin
            tb1_q <= tb1_q + 16'h0001;
         end
         if (tick2) begin
            tb2_q <= tb2_q + 16'h0001;
         end
      end
   end

   // =========================================================
   // channel pin synchronisers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         pin_s1_q   <= 16'h0000;
         pin_s2_q   <= 16'h0000;
         pin_prev_q <= 16'h0000;
      end else begin
         pin_s1_q   <= i_ch_pin;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // =========================================================
   // channels
   for (genvar c = 0; c < 16; c++) begin : g_ch
      logic [15:0] mtb, ctb;                                   // selected bases
      logic        rise, fall, eng_hit;
      assign mtb     = cfg_q[c].match_tb2 ? tb2_q : tb1_q;
      assign ctb     = cfg_q[c].cap_tb2 ? tb2_q : tb1_q;
      assign rise    = pin_s2_q[c] & ~pin_prev_q[c];
      assign fall    = ~pin_s2_q[c] & pin_prev_q[c];
      assign eng_hit = (state_q == time_processor_pkg::ST_EXEC) && (cur_q == 4'(c));
      assign match_evt[c] = cfg_q[c].armed && (mtb >= cmp_q[c]);
      assign capt_evt[c]  = !cfg_q[c].dir_out &&
                            ((rise && cfg_q[c].pin_action_field[0]) || (fall && cfg_q[c].pin_action_field[1]));
      assign link_set[c]  = (state_q == time_processor_pkg::ST_EXEC) &&
                            op_q[time_processor_pkg::OP_LINK] && (cur_q + 4'h1 == 4'(c));

      // setup, compare and pin driver written by the engine; a match disarms and drives the pin of an output channel
      always_ff @(posedge i_clock) begin
         if (!i_rst_n) begin
            cfg_q[c]        <= '0;
            cmp_q[c]        <= 16'h0000;
            o_ch_pin_out[c] <= 1'b0;
            o_ch_pin_oe[c]  <= 1'b0;
         end else if (eng_hit) begin
            cfg_q[c].pin_action_field       <= ctl_q[time_processor_pkg::CTL_PAC_LSB +: 2];
            cfg_q[c].dir_out   <= ctl_q[time_processor_pkg::CTL_DIR];
            cfg_q[c].match_tb2 <= ctl_q[time_processor_pkg::CTL_MTB2];
            cfg_q[c].cap_tb2   <= ctl_q[time_processor_pkg::CTL_CTB2];
            cfg_q[c].armed     <= ctl_q[time_processor_pkg::CTL_ARM] |
                                  op_q[time_processor_pkg::OP_REARM];
            o_ch_pin_oe[c]     <= ctl_q[time_processor_pkg::CTL_DIR];
            if (op_q[time_processor_pkg::OP_REARM]) begin
               cmp_q[c] <= cmp_q[c] + period_q;
            end
            if (ctl_q[time_processor_pkg::CTL_PSC_LSB +: 2] == time_processor_pkg::PSC_HIGH) begin
               o_ch_pin_out[c] <= 1'b1;
            end else if (ctl_q[time_processor_pkg::CTL_PSC_LSB +: 2] == time_processor_pkg::PSC_LOW) begin
               o_ch_pin_out[c] <= 1'b0;
            end
         end else if (match_evt[c]) begin
            cfg_q[c].armed <= 1'b0;                            // one match per arm
            if (cfg_q[c].dir_out) begin
               o_ch_pin_out[c] <= cfg_q[c].pin_action_field[0];
            end
         end
      end

      // capture register
      always_ff @(posedge i_clock) begin
         if (!i_rst_n) begin
            cap_q[c] <= 16'h0000;
         end else if (capt_evt[c]) begin
            cap_q[c] <= ctb;
         end
      end
   end : g_ch

   // =========================================================
   // service requests: set wins over clear at grant
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         req_q <= 16'h0000;
      end else begin
         req_q <= (req_q & ~(start ? (16'h0001 << grant) : 16'h0000)) |
                  i_host_req | link_set | match_evt | capt_evt;
      end
   end

   // =========================================================
   // scheduler
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         lvl_req[l] = 16'h0000;
         for (int k = 0; k < 16; k++) begin
            lvl_req[l][k] = req_q[k] && (i_ch_priority[2*k +: 2] == 2'(l));
         end
      end
      top_lvl = 2'h0;
      for (int l = 1; l < 4; l++) begin
         if (lvl_req[l] != 16'h0000) begin
            top_lvl = 2'(l);
         end
      end
      round_new = ((lvl_req[top_lvl] & ~done_q[top_lvl]) == 16'h0000);
      cand      = round_new ? lvl_req[top_lvl] : (lvl_req[top_lvl] & ~done_q[top_lvl]);
      grant     = lowest(cand);
      start     = (state_q == time_processor_pkg::ST_IDLE) && (top_lvl != 2'h0);
   end

   // served-this-round masks, one per level
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int l = 0; l < 4; l++) begin
            done_q[l] <= 16'h0000;
         end
      end else if (start) begin
         done_q[top_lvl] <= (round_new ? 16'h0000 : done_q[top_lvl]) |
                            (16'h0001 << grant);
      end
   end

   // =========================================================
   // microengine
   assign base = (cur_q < time_processor_pkg::LARGE_FIRST)
                 ? 7'({3'h0, cur_q} * time_processor_pkg::SLOT_SMALL)
                 : 7'(time_processor_pkg::LARGE_BASE + {3'h0, cur_q - time_processor_pkg::LARGE_FIRST}
                      * time_processor_pkg::SLOT_LARGE);

   // engine state machine
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_q <= time_processor_pkg::ST_IDLE;
         cur_q   <= 4'h0;
      end else begin
         case (state_q)
            time_processor_pkg::ST_IDLE: begin
               if (start) begin
                  cur_q   <= grant;
                  state_q <= time_processor_pkg::ST_FETCH;
               end
            end
            time_processor_pkg::ST_FETCH: begin
               state_q <= time_processor_pkg::ST_EXEC;
            end
            time_processor_pkg::ST_EXEC: begin
               state_q <= time_processor_pkg::ST_IDLE;
            end
            default: begin
               state_q <= time_processor_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // opcode and parameter fetch
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         op_q     <= 4'h0;
         ctl_q    <= 16'h0000;
         period_q <= 16'h0000;
         time_q   <= 16'h0000;
      end else if (state_q == time_processor_pkg::ST_FETCH) begin
         op_q     <= i_emu_select ? emu_ram_q[i_ch_function[4*cur_q +: 4]]
                     : time_processor_pkg::UCODE_ROM[4*i_ch_function[4*cur_q +: 4] +: 4];
         ctl_q    <= pram_q[base + time_processor_pkg::PW_CTL];
         period_q <= pram_q[base + time_processor_pkg::PW_PERIOD];
         time_q   <= pram_q[base + time_processor_pkg::PW_TIME];
      end
   end

   // emulation microcode store
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 16; k++) begin
            emu_ram_q[k] <= 4'h0;
         end
      end else if (i_emu_wr) begin
         emu_ram_q[i_emu_addr] <= i_emu_data;
      end
   end

   // status outputs
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_service_busy    <= 1'b0;
         o_service_channel <= 4'h0;
      end else begin
         o_service_busy    <= start || (state_q == time_processor_pkg::ST_FETCH);
         o_service_channel <= start ? grant : cur_q;
      end
   end

   // =========================================================
   // parameter memory: engine write wins, host waits one cycle
   assign eng_wr  = (state_q == time_processor_pkg::ST_EXEC) &&
                    op_q[time_processor_pkg::OP_STORE_CAPT];
   assign host_ok = i_host_pram.req && !eng_wr;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int k = 0; k < time_processor_pkg::PRAM_DEPTH; k++) begin
            pram_q[k] <= 16'h0000;
         end
      end else if (eng_wr) begin
         pram_q[base + time_processor_pkg::PW_CAPT] <= cap_q[cur_q];
      end else if (host_ok && i_host_pram.we) begin
         if (i_host_pram.long_acc) begin
            pram_q[{i_host_pram.addr[6:1], 1'b0}] <= i_host_pram.wdata[31:16];
            pram_q[{i_host_pram.addr[6:1], 1'b1}] <= i_host_pram.wdata[15:0];
         end else begin
            pram_q[i_host_pram.addr] <= i_host_pram.wdata[15:0];
         end
      end
   end

   // host read data and acknowledge
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_host_pram_rdata <= 32'h0000_0000;
         o_host_pram_ack   <= 1'b0;
      end else begin
         o_host_pram_ack <= host_ok;
         if (host_ok && !i_host_pram.we) begin
            o_host_pram_rdata <= i_host_pram.long_acc
               ? {pram_q[{i_host_pram.addr[6:1], 1'b0}],
                  pram_q[{i_host_pram.addr[6:1], 1'b1}]}
               : {16'h0000, pram_q[i_host_pram.addr]};
         end
      end
   end

   // =========================================================
   // assertions
   sequence s_service;
      state_q == time_processor_pkg::ST_FETCH ##1 state_q == time_processor_pkg::ST_EXEC
      ##1 state_q == time_processor_pkg::ST_IDLE;
   endsequence
   property p_service;
      @(posedge i_clock) disable iff (!i_rst_n) start |=> s_service;
   endproperty
   a_service: assert property (p_service) else $error("service sequence broken");
   property p_wrap;
      @(posedge i_clock) disable iff (!i_rst_n)
         (tick2 && tb2_q == time_processor_pkg::TB_MAX) |=> tb2_q == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("time base did not wrap");
   // first base wraps too; an engine load in the same cycle takes precedence
   property p_wrap1;
      @(posedge i_clock) disable iff (!i_rst_n)
         (tick1 && tb1_q == time_processor_pkg::TB_MAX &&
          state_q != time_processor_pkg::ST_EXEC) |=> tb1_q == 16'h0000;
   endproperty
   a_wrap1: assert property (p_wrap1) else $error("first time base did not wrap");
   property p_hold;
      @(posedge i_clock) disable iff (!i_rst_n) !tick2 |=> $stable(tb2_q);
   endproperty
   a_hold: assert property (p_hold) else $error("time base moved without tick");
   property p_req;
      @(posedge i_clock) disable iff (!i_rst_n)
         (i_host_req[0] || match_evt[0] || capt_evt[0]) |=> req_q[0];
   endproperty
   a_req: assert property (p_req) else $error("request cause lost");
   property p_grant;
      @(posedge i_clock) disable iff (!i_rst_n)
         start |-> cand[grant] && ((cand & ((16'h0001 << grant) - 16'h0001)) == 16'h0000);
   endproperty
   a_grant: assert property (p_grant) else $error("grant not lowest eligible");
   property p_round;
      @(posedge i_clock) disable iff (!i_rst_n)
         (start && !round_new) |-> !done_q[top_lvl][grant];
   endproperty
   a_round: assert property (p_round) else $error("channel served twice in round");
   property p_long;
      @(posedge i_clock) disable iff (!i_rst_n)
         (host_ok && i_host_pram.we && i_host_pram.long_acc) |=>
         {pram_q[{$past(i_host_pram.addr[6:1]), 1'b0}],
          pram_q[{$past(i_host_pram.addr[6:1]), 1'b1}]} == $past(i_host_pram.wdata);
   endproperty
   a_long: assert property (p_long) else $error("long write not coherent");
   property p_dir;
      @(posedge i_clock) disable iff (!i_rst_n)
         $changed(o_ch_pin_oe) |-> $past(state_q) == time_processor_pkg::ST_EXEC;
   endproperty
   a_dir: assert property (p_dir) else $error("direction changed outside engine");
endmodule : time_processor_core

//--- host_model.sv
// Purpose: host side of the parameter memory port
// Assumes: request held until ack, both seen at falling edge
// Notes:   long access moves an even/odd word pair at once
`timescale 1ns/1ns
module host_model (
   input  wire logic                            i_clock,
   input  wire logic                            i_ack,
   input  wire logic [31:0]                     i_rdata,
   output time_processor_pkg::host_pram_req_t   o_req
);
   // ==========================================================
   // one access, held until acknowledged or 20 cycles pass
   task automatic access(input logic we, input logic lg, input logic [6:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      do @(negedge i_clock); while (i_ack === 1'b1); // skip stray ack
      o_req = '{1'b1, we, lg, a, wd};
      while (i_ack !== 1'b1 && n < 20) begin
         @(negedge i_clock);
         n++;
      end
      rd = (i_ack === 1'b1) ? i_rdata : 'x; // no ack: unknown data fails the compare
      o_req = '0;
   endtask : access
   initial o_req = '0;
endmodule : host_model

//--- time_processor_core_bench.sv
// Purpose: self-checking bench for the time processor core
// Assumes: inputs change at falling edge
// Notes:   memory and scheduler order checked against bench models
`timescale 1ns/1ns
module time_processor_core_bench;
   logic clock, rst_n, ack, busy, bq; // clock, reset, outputs
   logic [15:0] host_req, cfg, pins, pout, poe; // stimulus and pins
   logic [31:0] prio, rdata, rd, wd; // priorities and data
   logic [3:0]  chan; // served channel
   logic [6:0]  a; // word address
   logic [63:0] fn; // function number per channel
   logic [3:0]  emu_addr, emu_data; // emulation store write
   logic        emu_sel, emu_wr; // emulation controls
   logic [15:0] mem [128]; // memory model
   logic [3:0]  served [$]; // service order seen
   int          fail_count, n_tests; // counters
   time_processor_pkg::host_pram_req_t hreq; // host request
   // ==========================================================
   always #25 clock = ~clock;
   host_model host (.i_clock(clock), .i_ack(ack), .i_rdata(rdata), .o_req(hreq));
   time_processor_core DUT (.i_clock(clock), .i_rst_n(rst_n),
      .i_module_config_word(cfg), .i_ext_timebase_clock_pin(pins[15]),
      .i_ch_pin(pins), .i_host_req(host_req), .i_ch_priority(prio),
      .i_ch_function(fn), .i_emu_select(emu_sel), .i_emu_wr(emu_wr),
      .i_emu_addr(emu_addr), .i_emu_data(emu_data), .i_host_pram(hreq),
      .o_host_pram_rdata(rdata), .o_host_pram_ack(ack), .o_ch_pin_out(pout),
      .o_ch_pin_oe(poe), .o_service_busy(busy), .o_service_channel(chan));
   // record each service start
   always @(negedge clock) begin
      if (busy === 1'b1 && bq !== 1'b1) served.push_back(chan);
      bq = busy;
   end
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   // pulse requests r, then compare order of services e: level first, channel next
   task automatic sched(input logic [31:0] p, input logic [15:0] r, input logic [15:0] e);
      @(negedge clock);
      prio = p;
      served.delete();
      @(negedge clock);
      host_req = r;
      @(negedge clock);
      host_req = '0;
      repeat (40) @(negedge clock);
      for (int lv = 3; lv > 0; lv--)
         for (int c = 0; c < 16; c++)
            if (e[c] && p[2*c+:2] == lv)
               check(served.size() ? {28'h0, served.pop_front()} : 'x, c);
      check(served.size(), 0);
   endtask : sched
   // ==========================================================
   initial begin
      void'($urandom(32'h7660));
      {clock, rst_n, host_req, prio, cfg, pins, emu_sel, emu_wr, emu_addr, emu_data} = '0;
      fn = 64'h111B_1111_1111_1111; // ch12 loads base1, others run no opcode
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      check({poe, pout}, 32'h0);
      cfg = 16'h000F & 16'($urandom);
      pins = 16'($urandom);
      for (int i = 0; i < 4; i++) begin
         a = {2'b11, 4'($urandom), 1'b0};
         wd = $urandom;
         host.access(1'b1, 1'b1, a, wd, rd);
         mem[a] = wd[31:16];
         mem[a+7'h1] = wd[15:0];
         host.access(1'b0, 1'b1, a, 32'h0, rd);
         check(rd, {mem[a], mem[a+7'h1]});
         host.access(1'b0, 1'b0, a + 7'h1, 32'h0, rd);
         check(rd, {16'h0, mem[a+7'h1]});
      end
      sched(32'h0000_0C10, 16'h0224, 16'h0224);
      sched(32'h0480_2000, 16'h2840, 16'h2840);
      // ch12: control forces pin high as output, time word loads top of base1
      host.access(1'b1, 1'b1, 7'h48, 32'h0011_0000, rd);
      host.access(1'b1, 1'b0, 7'h4B, 32'h0000_FFFF, rd);
      sched(32'h0300_0000, 16'h1000, 16'h1000);
      check({poe[12], pout[12]}, 32'h3);
      // emulation store: function 1 becomes a link to the next channel
      emu_wr = 1'b1;
      emu_addr = 4'h1;
      emu_data = 4'h4;
      @(negedge clock);
      emu_wr = 1'b0;
      emu_sel = 1'b1;
      sched(32'h0001_C000, 16'h0080, 16'h0180);
      final_report();
   end
   initial begin
      #1_000_000;
      fail_count++;
      final_report();
   end
endmodule : time_processor_core_bench
